// >>> pkg/dbs_pkg.sv
/*
 * dbs_pkg: constants and carrier types of the double-rate burst memory.
 * assumes one clock; each cycle carries two beats (true and complement edge).
 */
package dbs_pkg;
    // word and array geometry
    localparam int DBS_WORD_W = 18;
    localparam int DBS_ADDR_W = 6;
    localparam int DBS_BURST_LEN = 4;
    localparam int DBS_BURST_SHIFT = 2;
    localparam int DBS_MEM_DEPTH = (1 << DBS_ADDR_W) * DBS_BURST_LEN;
    localparam int DBS_MEM_AW = DBS_ADDR_W + DBS_BURST_SHIFT;
    // burst word offsets inside one address
    localparam logic [1:0] DBS_W0 = 2'h0;
    localparam logic [1:0] DBS_W1 = 2'h1;
    localparam logic [1:0] DBS_W2 = 2'h2;
    localparam logic [1:0] DBS_W3 = 2'h3;
    // address slot phase: read slot first after reset
    localparam logic DBS_PH_RD = 1'b0;
    localparam logic DBS_PH_WR = 1'b1;
    localparam logic DBS_ECHO_RST = 1'b0;

    // one beat of data with its valid bit
    typedef struct packed {
        logic valid;
        logic [DBS_WORD_W-1:0] data;
    } dbs_beat_s;

    // the two beats of one cycle: true edge first, complement edge second
    typedef struct packed {
        dbs_beat_s k;
        dbs_beat_s kb;
    } dbs_pair_s;

    // pins sampled from the controller
    typedef struct packed {
        logic [DBS_ADDR_W-1:0] addr;
        logic rd_sel_n;
        logic wr_sel_n;
        logic [DBS_WORD_W-1:0] d_k;
        logic [DBS_WORD_W-1:0] d_kb;
        logic pll_bypass_select;
    } dbs_pins_s;

    localparam dbs_pins_s DBS_PINS_RST = '{default: '0, rd_sel_n: 1'b1, wr_sel_n: 1'b1};
    localparam dbs_pair_s DBS_PAIR_RST = '0;

    typedef enum logic [1:0] {
        DBS_RS_IDLE = 2'b00,
        DBS_RS_LO = 2'b01,
        DBS_RS_HI = 2'b10
    } dbs_rstate_e;
endpackage

// >>> design/dbs_sram_core.sv
/*
 * dbs_sram_core: burst memory with separate read and write data ports,
 * a shared address bus, four-word bursts and two beats per cycle.
 * assumes the controller runs on i_clk and aligns reads and writes to the
 * alternating address slots, the read slot being first after reset.
 */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - addresses alternate read then write slots
// - each address moves four sequential words
// - data moves on both clock edges
// - only rising edges sample inputs
// - bypass high gives 2.5 cycle latency
// - bypass low gives one cycle latency
// - read and write run independently, concurrently
// - separate independent read and write selects
// - inputs registered before touching state
// - read data driven from output registers
// - writes self-timed on chip
// - valid flag marks read data present
// - echo clocks aligned with read data
// - read after write returns newest data
module dbs_sram_core
    import dbs_pkg::*;
(
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // controller pins
    input wire logic [DBS_ADDR_W-1:0] i_addr,
    input wire logic i_rd_sel_n,
    input wire logic i_wr_sel_n,
    input wire logic [DBS_WORD_W-1:0] i_d_k,
    input wire logic [DBS_WORD_W-1:0] i_d_kb,
    input wire logic i_pll_bypass_select,
    // read port
    output logic [DBS_WORD_W-1:0] o_q_k,
    output logic [DBS_WORD_W-1:0] o_q_kb,
    output logic [1:0] o_output_valid_flag,
    output logic [1:0] o_echo_timing_out
);
    dbs_pins_s pin_raw;
    dbs_pins_s sync1_reg, sync1_next, sync2_reg, sync2_next;
    logic phase_reg, phase_next;
    dbs_rstate_e rs_reg, rs_next;
    logic [DBS_ADDR_W-1:0] rd_addr_reg, rd_addr_next, wr_addr_reg, wr_addr_next;
    logic wr_hi_reg, wr_hi_next;
    logic [DBS_WORD_W-1:0] wr_d_k_reg, wr_d_k_next, wr_d_kb_reg, wr_d_kb_next;
    dbs_pair_s fetch;
    dbs_pair_s p1_reg, p1_next, out_reg, out_next;
    dbs_beat_s hold_reg, hold_next;
    logic echo_reg, echo_next;
    logic rd_take, wr_take;
    logic [DBS_WORD_W-1:0] mem [0:DBS_MEM_DEPTH-1];

    // word address inside the array for one burst slot
    function automatic logic [DBS_MEM_AW-1:0] dbs_word_addr(
        input logic [DBS_ADDR_W-1:0] a, input logic [1:0] w);
        dbs_word_addr = {a, w};
    endfunction

    assign pin_raw = '{addr: i_addr, rd_sel_n: i_rd_sel_n, wr_sel_n: i_wr_sel_n,
                       d_k: i_d_k, d_kb: i_d_kb, pll_bypass_select: i_pll_bypass_select};

    // two-stage input capture; stage one feeds only stage two
    always_comb begin
        sync1_next = i_ce ? pin_raw : sync1_reg;
        sync2_next = i_ce ? sync1_reg : sync2_reg;
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sync1_reg <= DBS_PINS_RST;
            sync2_reg <= DBS_PINS_RST;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    // slot decode: each select acts only in its own slot
    assign rd_take = i_ce && phase_reg == DBS_PH_RD && !sync2_reg.rd_sel_n;
    assign wr_take = i_ce && phase_reg == DBS_PH_WR && !sync2_reg.wr_sel_n;

    // address slot phase and read fetch sequencer
    always_comb begin
        phase_next = phase_reg;
        rs_next = rs_reg;
        rd_addr_next = rd_addr_reg;
        if (i_ce) begin
            phase_next = ~phase_reg;
            unique case (rs_reg)
                DBS_RS_IDLE: rs_next = DBS_RS_IDLE;
                DBS_RS_LO: rs_next = DBS_RS_HI;
                DBS_RS_HI: rs_next = DBS_RS_IDLE;
                default: rs_next = DBS_RS_IDLE;
            endcase
            if (rd_take) begin
                rs_next = DBS_RS_LO;
                rd_addr_next = sync2_reg.addr;
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            phase_reg <= DBS_PH_RD;
            rs_reg <= DBS_RS_IDLE;
            rd_addr_reg <= '0;
        end else begin
            phase_reg <= phase_next;
            rs_reg <= rs_next;
            rd_addr_reg <= rd_addr_next;
        end
    end

    // write sequencer: words 0,1 land with the address, 2,3 one cycle later
    always_comb begin
        wr_hi_next = wr_hi_reg;
        wr_addr_next = wr_addr_reg;
        wr_d_k_next = wr_d_k_reg;
        wr_d_kb_next = wr_d_kb_reg;
        if (i_ce) begin
            wr_hi_next = wr_take;
            if (wr_take) begin
                wr_addr_next = sync2_reg.addr;
            end
            wr_d_k_next = sync2_reg.d_k;
            wr_d_kb_next = sync2_reg.d_kb;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_hi_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_d_k_reg <= '0;
            wr_d_kb_reg <= '0;
        end else begin
            wr_hi_reg <= wr_hi_next;
            wr_addr_reg <= wr_addr_next;
            wr_d_k_reg <= wr_d_k_next;
            wr_d_kb_reg <= wr_d_kb_next;
        end
    end

    // array writes; no strobe timing asked of the controller
    always_ff @(posedge i_clk) begin
        if (i_rst_n && wr_take) begin
            mem[dbs_word_addr(sync2_reg.addr, DBS_W0)] <= sync2_reg.d_k;
            mem[dbs_word_addr(sync2_reg.addr, DBS_W1)] <= sync2_reg.d_kb;
        end
        if (i_rst_n && i_ce && wr_hi_reg) begin
            mem[dbs_word_addr(wr_addr_reg, DBS_W2)] <= sync2_reg.d_k;
            mem[dbs_word_addr(wr_addr_reg, DBS_W3)] <= sync2_reg.d_kb;
        end
    end

    // fetch reads the array after the write slot has committed, so a
    // read issued after a write always sees it without a bypass path
    always_comb begin
        fetch = DBS_PAIR_RST;
        unique case (rs_reg)
            DBS_RS_IDLE: fetch = DBS_PAIR_RST;
            DBS_RS_LO: begin
                fetch.k = '{valid: 1'b1, data: mem[dbs_word_addr(rd_addr_reg, DBS_W0)]};
                fetch.kb = '{valid: 1'b1, data: mem[dbs_word_addr(rd_addr_reg, DBS_W1)]};
            end
            DBS_RS_HI: begin
                fetch.k = '{valid: 1'b1, data: mem[dbs_word_addr(rd_addr_reg, DBS_W2)]};
                fetch.kb = '{valid: 1'b1, data: mem[dbs_word_addr(rd_addr_reg, DBS_W3)]};
            end
            default: fetch = DBS_PAIR_RST;
        endcase
    end

    // output stage; bypass high slides the stream by three beats
    always_comb begin
        p1_next = p1_reg;
        hold_next = hold_reg;
        out_next = out_reg;
        echo_next = echo_reg;
        if (i_ce) begin
            p1_next = fetch;
            hold_next = p1_reg.kb;
            echo_next = ~echo_reg;
            if (sync2_reg.pll_bypass_select) begin
                out_next.k = hold_reg;
                out_next.kb = p1_reg.k;
            end else begin
                out_next = fetch;
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            p1_reg <= DBS_PAIR_RST;
            hold_reg <= DBS_PAIR_RST.k;
            out_reg <= DBS_PAIR_RST;
            echo_reg <= DBS_ECHO_RST;
        end else begin
            p1_reg <= p1_next;
            hold_reg <= hold_next;
            out_reg <= out_next;
            echo_reg <= echo_next;
        end
    end

    // outputs straight from registers, except the complement echo bit, which passes through an inverter
    assign o_q_k = out_reg.k.data;
    assign o_q_kb = out_reg.kb.data;
    assign o_output_valid_flag = {out_reg.k.valid, out_reg.kb.valid};
    assign o_echo_timing_out = {echo_reg, ~echo_reg};

    a_phase_toggles: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce |=> phase_reg != $past(phase_reg))
        else $error("address slot phase did not alternate");
    a_read_only_rdslot: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && phase_reg == DBS_PH_WR && rs_reg != DBS_RS_LO) |=> rs_reg != DBS_RS_LO)
        else $error("read started in write slot");
    a_burst_hi_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && rs_reg == DBS_RS_LO) |=> rs_reg == DBS_RS_HI)
        else $error("second burst half missing");
    a_write_second_half: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_take |=> wr_hi_reg && wr_addr_reg == $past(sync2_reg.addr))
        else $error("write burst second half not scheduled");
    a_valid_bypass_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && rs_reg == DBS_RS_LO && !sync2_reg.pll_bypass_select) |=> o_output_valid_flag == 2'b11)
        else $error("one cycle latency valid missing");
    a_valid_bypass_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && rs_reg == DBS_RS_LO && sync2_reg.pll_bypass_select) ##1 i_ce ##1 i_ce
        |=> o_output_valid_flag == 2'b11)
        else $error("late latency valid missing");
    a_valid_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && rs_reg == DBS_RS_IDLE && !hold_reg.valid) |=> !o_output_valid_flag[1])
        else $error("valid set with no read data");
    a_echo_runs: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce |=> o_echo_timing_out[1] != $past(o_echo_timing_out[1]) && ^o_echo_timing_out)
        else $error("echo clocks not toggling as a pair");
endmodule
`default_nettype wire

// >>> sim/dbs_ctrl_model.sv
/*
 * dbs_ctrl_model: memory controller model driving the shared pins.
 * assumes pins change at the falling edge and the read slot is first after reset.
 */
`timescale 1ns/1ps
`default_nettype none
module dbs_ctrl_model
    import dbs_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // pins to the memory
    output var dbs_pins_s o_pins
);
    logic ph_reg = DBS_PH_RD;

    // slot tracker, mirrors the memory's read/write alternation
    always @(posedge i_clk) ph_reg <= i_rst_n ? ~ph_reg : DBS_PH_RD;
    initial o_pins = DBS_PINS_RST;

    // write burst, optionally a read of the same address in the following slot
    task automatic wr(input logic [DBS_ADDR_W-1:0] a, input logic [71:0] w, input logic rd, input logic sel);
        do @(negedge i_clk); while (ph_reg !== DBS_PH_WR);
        o_pins.addr = a;
        o_pins.wr_sel_n = ~sel;
        {o_pins.d_k, o_pins.d_kb} = w[71:36];
        @(negedge i_clk);
        o_pins.wr_sel_n = 1'b1;
        o_pins.rd_sel_n = ~rd;
        {o_pins.d_k, o_pins.d_kb} = w[35:0];
        @(negedge i_clk);
        o_pins.rd_sel_n = 1'b1;
        o_pins.addr = ~a;
        // released data lines must not keep showing the last word
        {o_pins.d_k, o_pins.d_kb} = ~w[35:0];
    endtask

    // single read request in a read slot
    task automatic rd(input logic [DBS_ADDR_W-1:0] a, input logic sel);
        do @(negedge i_clk); while (ph_reg !== DBS_PH_RD);
        o_pins.addr = a;
        o_pins.rd_sel_n = ~sel;
        @(negedge i_clk);
        o_pins.rd_sel_n = 1'b1;
        o_pins.addr = ~a;
    endtask

    // latency mode change, then idle so the synchronised level settles
    task automatic byp(input logic b);
        @(negedge i_clk);
        o_pins.pll_bypass_select = b;
        repeat (6) @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
/*
 * testbench: directed scenarios for dbs_sram_core through the controller model.
 * assumes one 40 MHz clock, clock enable held high except in one two-cycle freeze, reset held two cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dbs_pkg::*;
    localparam logic [71:0] W1 = 72'h01_2345_6789_abcd_ef01;
    localparam logic [71:0] W2 = 72'hfe_dcba_9876_5432_10fe;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    dbs_pins_s pins;
    logic [DBS_WORD_W-1:0] q_k, q_kb;
    logic [1:0] vld, echo;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int first_lo;

    dbs_ctrl_model m (.i_clk(clk), .i_rst_n(rst_n), .o_pins(pins));
    // clock enable dropped only in an even-length freeze, so the model's slot count stays aligned
    dbs_sram_core dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(pins.addr),
        .i_rd_sel_n(pins.rd_sel_n), .i_wr_sel_n(pins.wr_sel_n), .i_d_k(pins.d_k), .i_d_kb(pins.d_kb),
        .i_pll_bypass_select(pins.pll_bypass_select), .o_q_k(q_k), .o_q_kb(q_kb),
        .o_output_valid_flag(vld), .o_echo_timing_out(echo));

    initial forever #12.5 clk = ~clk;

    task automatic complete_run;
        if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, well above the hundred or so cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            complete_run;
        end
    end

    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // gather valid beats in true-then-complement order; echo checked every cycle
    task automatic collect(output int n, output logic [71:0] got, output logic [1:0] ff, output int first);
        logic pe;
        n = 0;
        got = '0;
        ff = 2'b00;
        first = -1;
        pe = echo[1];
        for (int c = 1; c < 12; c++) begin
            @(negedge clk);
            chk({71'h0, echo[0]}, {71'h0, ~echo[1]});
            chk({71'h0, echo[1]}, {71'h0, ~pe});
            pe = echo[1];
            if (first < 0 && vld !== 2'b00) ff = vld;
            if (vld[1] === 1'b1) begin
                got = {got[53:0], q_k};
                n++;
                if (first < 0) first = 2 * c;
            end
            if (vld[0] === 1'b1) begin
                got = {got[53:0], q_kb};
                n++;
                if (first < 0) first = 2 * c + 1;
            end
        end
    endtask

    task automatic t_low_read;
        int n, f;
        logic [71:0] g;
        logic [1:0] ff;
        m.wr(6'h05, W1, 1'b0, 1'b1);
        m.rd(6'h05, 1'b1);
        collect(n, g, ff, first_lo);
        chk(72'(n), 72'h4);
        chk(g, W1);
        chk({70'h0, ff}, 72'h3);
    endtask

    task automatic t_high_read;
        int n, f;
        logic [71:0] g;
        logic [1:0] ff;
        m.byp(1'b1);
        m.rd(6'h05, 1'b1);
        collect(n, g, ff, f);
        chk(g, W1);
        chk({70'h0, ff}, 72'h1);
        chk(72'(f - first_lo), 72'h3);
        m.byp(1'b0);
    endtask

    task automatic t_raw;
        int n, f;
        logic [71:0] g;
        logic [1:0] ff;
        m.wr(6'h09, W2, 1'b1, 1'b1);
        collect(n, g, ff, f);
        chk(g, W2);
    endtask

    task automatic t_selects;
        int n, f;
        logic [71:0] g;
        logic [1:0] ff;
        m.wr(6'h09, W1, 1'b0, 1'b0);
        m.rd(6'h09, 1'b1);
        collect(n, g, ff, f);
        chk(g, W2);
        m.rd(6'h09, 1'b0);
        collect(n, g, ff, f);
        chk(72'(n), 72'h0);
    endtask

    // enable low for two edges: echo must stand still and valid stay low
    task automatic t_freeze;
        logic [1:0] e;
        @(negedge clk);
        e = echo;
        ce = 1'b0;
        repeat (2) @(negedge clk);
        chk({70'h0, echo}, {70'h0, e});
        chk({70'h0, vld}, 72'h0);
        ce = 1'b1;
    endtask

    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_low_read;
        t_high_read;
        t_raw;
        t_selects;
        t_freeze;
        t_raw;
        complete_run;
    end
endmodule
`default_nettype wire
